/* File: logic/tws_pkg.sv */
// constants and state codes of the three-wire control slave
// assumes one system clock; all bus pins arrive asynchronously
package tws_pkg;

   // ----------------------------------------------------------------
   // transfer-type field, read as {bit 1, bit 0}
   // ----------------------------------------------------------------
   localparam logic [1:0] TT_WRITE_PREP = 2'h2;
   localparam logic [1:0] TT_READ       = 2'h3;

   // ----------------------------------------------------------------
   // device address, fixed part {bit 7, bit 6, bit 5, bit 4}
   // ----------------------------------------------------------------
   localparam logic [3:0] DEV_ADDR_FIXED = 4'h1;

   // ----------------------------------------------------------------
   // byte and frame sizes
   // ----------------------------------------------------------------
   localparam logic [4:0] BYTE_LAST_BIT  = 5'h07;
   localparam logic [4:0] READ_FRAME_BITS = 5'h18;

   // ----------------------------------------------------------------
   // data-phase byte positions of a write
   // ----------------------------------------------------------------
   localparam logic [1:0] BYTE_REG_ADDR = 2'h0;
   localparam logic [1:0] BYTE_DATA_HI  = 2'h1;
   localparam logic [1:0] BYTE_DATA_LO  = 2'h2;
   localparam logic [1:0] BYTE_SPENT    = 2'h3;

   // ----------------------------------------------------------------
   // power-up string registers
   // ----------------------------------------------------------------
   localparam logic [6:0]  INIT_REG_ADDR     = 7'h40;
   localparam logic [15:0] INIT_REG_DATA     = 16'h0001;
   localparam logic [6:0]  DEFAULTS_REG_ADDR = 7'h7F;
   localparam logic [15:0] DEFAULTS_REG_DATA = 16'h0000;

   // ----------------------------------------------------------------
   // protocol states
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_ADDR   = 4'h1,
      ST_WRITE  = 4'h2,
      ST_READ   = 4'h4,
      ST_IGNORE = 4'h8
   } tws_state_type;

   localparam tws_state_type ST_RESET = ST_ADDR;

endpackage

/* File: logic/tws_slave.sv */
// three-wire serial control slave: address phase, register write,
// prepare-read and read-back of 16-bit registers
// assumes the bus clock is far slower than clk (at least 4 clk per level)
//
// Overview of operation
// - bytes move bit 0 first, bit 7 last
// - mode low plus 8 clocks is address
// - mode high carries data bytes
// - address byte: type bits 0-1, address 2-7
// - respond to fixed address with strap bits
// - type 10 write/prepare, 11 read
// - first data byte: flag bit 0, address 1-7
// - register address sent A6 first, A0 last
// - data sent D15 first, D0 last
// - device returns address, high, low bytes
// - returned bit 0 low means valid register
// - set-defaults write restores default settings
// - port active only with bus-type pin low; iface_awake still sets on any bus clock rise
module tws_slave (
   // system
   input  wire logic        clk,
   input  wire logic        rst,
   // serial bus pins
   input  wire logic        ctl_serial_clock_line,
   input  wire logic        ctl_phase_select_line,
   input  wire logic        ctl_serial_data_line_i,
   output logic             ctl_serial_data_line_o,
   output logic             ctl_serial_data_line_oe,
   // straps
   input  wire logic        bus_type_select_pin,
   input  wire logic        addr_strap_low,
   input  wire logic        addr_strap_high,
   // register write side
   output logic             reg_wr_pulse,
   output logic [6:0]       reg_wr_addr,
   output logic [15:0]      reg_wr_data,
   output logic             set_defaults_pulse,
   output logic             pll_init_seen,
   // register read side
   output logic [6:0]       reg_rd_addr,
   input  wire logic [15:0] reg_rd_data,
   input  wire logic        reg_rd_valid,
   // status
   output logic             iface_awake
);

   // ----------------------------------------------------------------
   // module state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [5:0]             s1;
      logic [5:0]             s2;
      logic                   clk_prev;
      logic                   mode_prev;
      tws_pkg::tws_state_type state;
      tws_pkg::tws_state_type next_kind;
      logic [4:0]             bit_cnt;
      logic [1:0]             byte_idx;
      logic [7:0]             rx_sh;
      logic [23:0]            tx_sh;
      logic                   shift_due;
      logic                   sd_o;
      logic                   sd_oe;
      logic                   wr_pulse;
      logic [6:0]             wr_addr;
      logic [15:0]            wr_data;
      logic                   dflt_pulse;
      logic                   init_seen;
      logic [6:0]             rd_addr;
      logic                   awake;
   } tws_st_type;

   localparam tws_st_type ST_INIT = '{
      // bus clock chain starts at its idle-high level: no false edge
      s1:        6'h01,
      s2:        6'h01,
      clk_prev:  1'b1,
      mode_prev: 1'b0,
      state:     tws_pkg::ST_RESET,
      next_kind: tws_pkg::ST_IGNORE,
      bit_cnt:   5'h00,
      byte_idx:  2'h0,
      rx_sh:     8'h00,
      tx_sh:     24'h000000,
      shift_due: 1'b0,
      sd_o:      1'b0,
      sd_oe:     1'b0,
      wr_pulse:  1'b0,
      wr_addr:   7'h00,
      wr_data:   16'h0000,
      dflt_pulse: 1'b0,
      init_seen: 1'b0,
      rd_addr:   7'h00,
      awake:     1'b0
   };

   tws_st_type r;
   tws_st_type n;

   // synchronised pin levels
   logic       clk_s;
   logic       mode_s;
   logic       data_s;
   logic       sel_s;
   logic       clk_rise;
   logic       clk_fall;
   logic       mode_rise;
   logic       mode_fall;
   logic [7:0] new_byte;
   logic [1:0] type_fld;
   logic       addr_hit;

   assign clk_s     = r.s2[0];
   assign mode_s    = r.s2[1];
   assign data_s    = r.s2[2];
   assign sel_s     = r.s2[3];
   assign clk_rise  = clk_s & ~r.clk_prev;
   assign clk_fall  = ~clk_s & r.clk_prev;
   assign mode_rise = mode_s & ~r.mode_prev;
   assign mode_fall = ~mode_s & r.mode_prev;

   // first bit lands in bit 7
   assign new_byte = {r.rx_sh[6:0], data_s};

   // type field from first two bits
   assign type_fld = {new_byte[6], new_byte[7]};

   assign addr_hit = ({new_byte[0], new_byte[1], new_byte[2], new_byte[3]}
                      == tws_pkg::DEV_ADDR_FIXED)
                     && (new_byte[5] == r.s2[4])
                     && (new_byte[4] == r.s2[5]);

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      n            = r;
      // straps share the two-flop chain of the bus pins
      n.s1         = {addr_strap_high, addr_strap_low,
                      bus_type_select_pin, ctl_serial_data_line_i,
                      ctl_phase_select_line, ctl_serial_clock_line};
      n.s2         = r.s1;
      n.clk_prev   = clk_s;
      n.mode_prev  = mode_s;
      n.wr_pulse   = 1'b0;
      n.dflt_pulse = 1'b0;

      // first clock pulse marks the port awake
      if (clk_rise) begin
         n.awake = 1'b1;
      end

      if (sel_s) begin
         // other bus type owns the pins
         n.state     = tws_pkg::ST_ADDR;
         n.next_kind = tws_pkg::ST_IGNORE;
         n.bit_cnt   = 5'h00;
         n.shift_due = 1'b0;
         n.sd_oe     = 1'b0;
      end else if (mode_fall) begin
         n.state     = tws_pkg::ST_ADDR;
         n.next_kind = tws_pkg::ST_IGNORE;
         n.bit_cnt   = 5'h00;
         n.shift_due = 1'b0;
         n.sd_oe     = 1'b0;
      end else if (mode_rise) begin
         // data phase takes the decoded kind
         n.state     = (r.state == tws_pkg::ST_ADDR) ? r.next_kind
                                                     : tws_pkg::ST_IGNORE;
         n.bit_cnt   = 5'h00;
         n.byte_idx  = tws_pkg::BYTE_REG_ADDR;
         n.shift_due = 1'b0;
         // first read bit drives before first rise
         if (r.state == tws_pkg::ST_ADDR
             && r.next_kind == tws_pkg::ST_READ) begin
            n.sd_oe = 1'b1;
            n.sd_o  = r.tx_sh[23];
         end
      end else begin
         unique case (r.state)
            tws_pkg::ST_ADDR: begin
               if (clk_rise && !mode_s
                   && r.bit_cnt <= tws_pkg::BYTE_LAST_BIT) begin
                  n.rx_sh   = new_byte;
                  n.bit_cnt = r.bit_cnt + 5'h01;
                  if (r.bit_cnt == tws_pkg::BYTE_LAST_BIT) begin
                     if (addr_hit && type_fld == tws_pkg::TT_WRITE_PREP) begin
                        n.next_kind = tws_pkg::ST_WRITE;
                     end else if (addr_hit
                                  && type_fld == tws_pkg::TT_READ) begin
                        n.next_kind = tws_pkg::ST_READ;
                        n.tx_sh = {~reg_rd_valid, r.rd_addr, reg_rd_data};
                     end else begin
                        n.next_kind = tws_pkg::ST_IGNORE;
                     end
                  end
               end
            end
            tws_pkg::ST_WRITE: begin
               if (clk_rise && mode_s) begin
                  n.rx_sh   = new_byte;
                  n.bit_cnt = r.bit_cnt + 5'h01;
                  if (r.bit_cnt == tws_pkg::BYTE_LAST_BIT) begin
                     n.bit_cnt = 5'h00;
                     unique case (r.byte_idx)
                        tws_pkg::BYTE_REG_ADDR: begin
                           if (new_byte[7]) begin
                              n.rd_addr = new_byte[6:0];
                              n.state   = tws_pkg::ST_IGNORE;
                           end else begin
                              n.wr_addr  = new_byte[6:0];
                              n.byte_idx = tws_pkg::BYTE_DATA_HI;
                           end
                        end
                        tws_pkg::BYTE_DATA_HI: begin
                           n.wr_data[15:8] = new_byte;
                           n.byte_idx      = tws_pkg::BYTE_DATA_LO;
                        end
                        tws_pkg::BYTE_DATA_LO: begin
                           n.wr_data[7:0] = new_byte;
                           n.wr_pulse     = 1'b1;
                           n.byte_idx     = tws_pkg::BYTE_SPENT;
                           if (r.wr_addr == tws_pkg::INIT_REG_ADDR
                               && {r.wr_data[15:8], new_byte}
                                  == tws_pkg::INIT_REG_DATA) begin
                              n.init_seen = 1'b1;
                           end
                           if (r.wr_addr == tws_pkg::DEFAULTS_REG_ADDR
                               && {r.wr_data[15:8], new_byte}
                                  == tws_pkg::DEFAULTS_REG_DATA) begin
                              n.dflt_pulse = 1'b1;
                           end
                        end
                        tws_pkg::BYTE_SPENT: begin
                           n.state = tws_pkg::ST_IGNORE;
                        end
                     endcase
                  end
               end
            end
            tws_pkg::ST_READ: begin
               // count bits on rise, advance after fall
               if (clk_rise && mode_s
                   && r.bit_cnt < tws_pkg::READ_FRAME_BITS) begin
                  n.bit_cnt   = r.bit_cnt + 5'h01;
                  n.shift_due = 1'b1;
               end
               if (clk_fall && r.shift_due) begin
                  n.shift_due = 1'b0;
                  if (r.bit_cnt == tws_pkg::READ_FRAME_BITS) begin
                     n.sd_oe = 1'b0;
                     n.state = tws_pkg::ST_IGNORE;
                  end else begin
                     n.tx_sh = {r.tx_sh[22:0], 1'b0};
                     n.sd_o  = r.tx_sh[22];
                  end
               end
            end
            tws_pkg::ST_IGNORE: begin
               n.bit_cnt = 5'h00;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         r <= ST_INIT;
      end else begin
         r <= n;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign ctl_serial_data_line_o  = r.sd_o;
   assign ctl_serial_data_line_oe = r.sd_oe;
   assign reg_wr_pulse            = r.wr_pulse;
   assign reg_wr_addr             = r.wr_addr;
   assign reg_wr_data             = r.wr_data;
   assign set_defaults_pulse      = r.dflt_pulse;
   assign pll_init_seen           = r.init_seen;
   assign reg_rd_addr             = r.rd_addr;
   assign iface_awake             = r.awake;

endmodule

/* File: testbench/testbench.sv */
// self-checking bench of the three-wire control slave
// host model drives the bus; bench drives straps and read data
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        ctl_serial_clock_line;
   logic        ctl_phase_select_line;
   logic        ctl_serial_data_line;
   logic        ctl_serial_data_line_o;
   logic        ctl_serial_data_line_oe;
   logic        bus_type_select_pin = 1'b0;
   logic        addr_strap_low = 1'b0;
   logic        addr_strap_high = 1'b0;
   logic        reg_wr_pulse;
   logic [6:0]  reg_wr_addr;
   logic [15:0] reg_wr_data;
   logic        set_defaults_pulse;
   logic        pll_init_seen;
   logic [6:0]  reg_rd_addr;
   logic [15:0] reg_rd_data = 16'h0000;
   logic        reg_rd_valid = 1'b0;
   logic        iface_awake;
   int          error_cnt = 0;
   int          n_tests = 0;
   int          def_cnt = 0;
   int          def_exp = 0;
   logic [22:0] exp_q[$];
   logic [6:0]  wa;
   logic [15:0] wd;
   tws_slave tws_slave_inst (
      .clk, .rst, .ctl_serial_clock_line, .ctl_phase_select_line,
      .ctl_serial_data_line_i(ctl_serial_data_line),
      .ctl_serial_data_line_o, .ctl_serial_data_line_oe, .bus_type_select_pin,
      .addr_strap_low, .addr_strap_high, .reg_wr_pulse, .reg_wr_addr,
      .reg_wr_data, .set_defaults_pulse, .pll_init_seen, .reg_rd_addr,
      .reg_rd_data, .reg_rd_valid, .iface_awake);
   tws_host_model host_inst (
      .ctl_serial_clock_line, .ctl_phase_select_line, .ctl_serial_data_line,
      .dev_data(ctl_serial_data_line_o), .dev_oe(ctl_serial_data_line_oe));
   initial begin
      forever #4 clk = ~clk;
   end
   // ----------------------------------------------------------------
   // model helpers
   // ----------------------------------------------------------------
   function automatic logic [7:0] rev8(input logic [7:0] x);
      return {<<{x}};
   endfunction
   function automatic logic [7:0] dev_byte(input logic [1:0] tt);
      return {4'h1, addr_strap_high, addr_strap_low, tt};
   endfunction
   task automatic chk(input logic [23:0] act, input logic [23:0] exp);
      n_tests++;
      if (act !== exp) begin
         error_cnt++;
         $display("Error %0t: got %h expected %h", $time, act, exp);
      end
   endtask
   task automatic wrap_up();
      if (error_cnt == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic settle();
      int k;
      for (k = 0; k < 40 && exp_q.size() != 0; k++) @(posedge clk);
      chk(24'(exp_q.size()), 24'h0);
      if (k == 40) wrap_up();
      if (k > 0) #3;
   endtask
   always @(posedge clk) begin
      if (!rst && reg_wr_pulse === 1'b1) begin
         chk(24'(exp_q.size() > 0), 24'h1);
         if (exp_q.size() > 0) begin
            chk({reg_wr_addr, reg_wr_data}, exp_q.pop_front());
         end
      end
      if (!rst && set_defaults_pulse === 1'b1) def_cnt++;
   end
   task automatic do_write(input logic [7:0] dv, input logic [6:0] a,
                           input logic [15:0] d, input int nb, input bit ok);
      host_inst.send_byte(dv, 1'b0);
      host_inst.send_byte(rev8({1'b0, a}), 1'b1);
      host_inst.send_byte(rev8(d[15:8]), 1'b1);
      if (ok) exp_q.push_back({a, d});
      if (ok && a == 7'h7F && d == 16'h0000) def_exp++;
      if (nb > 3) host_inst.send_byte(rev8(d[7:0]), 1'b1);
      host_inst.end_frame();
      settle();
   endtask
   task automatic do_read(input logic [6:0] a, input logic [15:0] d,
                          input logic v);
      logic [7:0] b0, b1, b2;
      logic [23:0] ex;
      host_inst.send_byte(dev_byte(2'h2), 1'b0);
      host_inst.send_byte(rev8({1'b1, a}), 1'b1);
      host_inst.end_frame();
      chk(24'(reg_rd_addr), 24'(a));
      @(posedge clk);
      reg_rd_data <= d;
      reg_rd_valid <= v;
      #3;
      host_inst.send_byte(dev_byte(2'h3), 1'b0);
      host_inst.get_byte(b0);
      host_inst.get_byte(b1);
      host_inst.get_byte(b2);
      host_inst.end_frame();
      ex = {rev8({~v, a}), rev8(d[15:8]), rev8(d[7:0])};
      chk({b0, b1, b2}, ex);
   endtask
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      void'($urandom(32'h0215));
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      repeat (5) @(posedge clk);
      #3;
      chk(24'(iface_awake), 24'h0);
      host_inst.pulse_bit(1'b1);
      chk(24'(iface_awake), 24'h1);
      do_write(dev_byte(2'h2), 7'h40, 16'h0001, 4, 1);
      chk(24'(pll_init_seen), 24'h1);
      do_write(dev_byte(2'h2), 7'h7F, 16'h0000, 4, 1);
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         {addr_strap_high, addr_strap_low} <= 2'($urandom());
         @(posedge clk);
         #3;
         wa = 7'($urandom);
         wd = 16'($urandom);
         do_write(dev_byte(2'h2), wa, wd, 4, 1);
         do_read(7'($urandom), 16'($urandom), 1'($urandom));
      end
      do_write(dev_byte(2'h0), 7'h11, 16'h1234, 4, 0);
      do_write(dev_byte(2'h1), 7'h11, 16'h1234, 4, 0);
      do_write(dev_byte(2'h2) ^ 8'h20, 7'h12, 16'h55AA, 4, 0);
      do_write(dev_byte(2'h2), 7'h13, 16'hA55A, 3, 0);
      @(posedge clk);
      bus_type_select_pin <= 1'b1;
      #3;
      do_write(dev_byte(2'h2), 7'h14, 16'h0F0F, 4, 0);
      chk(24'(def_cnt), 24'(def_exp));
      wrap_up();
   end
endmodule

/* File: testbench/tws_host_model.sv */
// host model driving the three-wire control bus
// bus clock idles high and stands still between frames
module tws_host_model (
   // bus wires
   output logic      ctl_serial_clock_line,
   output logic      ctl_phase_select_line,
   output logic      ctl_serial_data_line,
   // device side of the data pin
   input  wire logic dev_data,
   input  wire logic dev_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   logic drv_en = 1'b1;
   logic drv_d = 1'b1;
   logic rel_d = 1'b0;
   // released line shows the inverse of the last driven bit
   assign ctl_serial_data_line = dev_oe ? dev_data : (drv_en ? drv_d : rel_d);
   initial begin
      ctl_serial_clock_line = 1'b1;
      ctl_phase_select_line = 1'b1;
   end
   task automatic pulse_bit(input logic b);
      ctl_serial_clock_line = 1'b0;
      drv_d = b;
      #40;
      ctl_serial_clock_line = 1'b1;
      #40;
   endtask
   // bit 0 first, mode low marks address
   task automatic send_byte(input logic [7:0] b, input logic mode);
      ctl_phase_select_line = mode;
      drv_en = 1'b1;
      #40;
      for (int i = 0; i < 8; i++) pulse_bit(b[i]);
   endtask
   task automatic get_byte(output logic [7:0] b);
      rel_d = ~drv_d;
      drv_en = 1'b0;
      if (!ctl_phase_select_line) begin
         ctl_phase_select_line = 1'b1;
         #40;
      end
      for (int i = 0; i < 8; i++) begin
         ctl_serial_clock_line = 1'b0;
         #40;
         b[i] = ctl_serial_data_line;
         ctl_serial_clock_line = 1'b1;
         #40;
      end
   endtask
   task automatic end_frame();
      #40;
      ctl_phase_select_line = 1'b0;
      #80;
   endtask
endmodule

/* File: testbench/tws_slave_assertions.sv */
// assertion checker of the three-wire control slave
// bound to tws_slave; sees only its ports
module tws_slave_assertions (
   // system
   input wire logic        clk,
   input wire logic        rst,
   // bus pins
   input wire logic        ctl_serial_clock_line,
   input wire logic        ctl_phase_select_line,
   input wire logic        ctl_serial_data_line_o,
   input wire logic        ctl_serial_data_line_oe,
   input wire logic        bus_type_select_pin,
   // user side
   input wire logic        reg_wr_pulse,
   input wire logic [6:0]  reg_wr_addr,
   input wire logic [15:0] reg_wr_data,
   input wire logic        set_defaults_pulse,
   input wire logic        pll_init_seen,
   input wire logic        iface_awake
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   sequence s_other_bus;
      bus_type_select_pin [*6];
   endsequence
   sequence s_addr_phase;
      !ctl_phase_select_line [*6];
   endsequence
   property p_other_bus_quiet;
      s_other_bus |-> !ctl_serial_data_line_oe;
   endproperty
   a_other_bus_quiet: assert property (p_other_bus_quiet)
      else $error("data line driven while other bus type selected");
   property p_release_in_addr;
      s_addr_phase |-> !ctl_serial_data_line_oe;
   endproperty
   a_release_in_addr: assert property (p_release_in_addr)
      else $error("data line still driven in address phase");
   property p_drive_after_fall;
      ctl_serial_data_line_oe && $past(ctl_serial_data_line_oe)
         && $changed(ctl_serial_data_line_o)
         |-> !$past(ctl_serial_clock_line, 3);
   endproperty
   a_drive_after_fall: assert property (p_drive_after_fall)
      else $error("read bit changed while bus clock high");
   property p_oe_start;
      $rose(ctl_serial_data_line_oe)
         |-> ctl_phase_select_line && $past(ctl_phase_select_line, 2);
   endproperty
   a_oe_start: assert property (p_oe_start)
      else $error("read drive began outside data phase");
   property p_wr_single;
      reg_wr_pulse |=> !reg_wr_pulse;
   endproperty
   a_wr_single: assert property (p_wr_single)
      else $error("write strobe longer than one cycle");
   property p_wr_in_data;
      reg_wr_pulse |-> $past(ctl_phase_select_line, 3);
   endproperty
   a_wr_in_data: assert property (p_wr_in_data)
      else $error("write completed outside data phase");
   property p_defaults;
      set_defaults_pulse |-> reg_wr_pulse && reg_wr_addr == 7'h7F
         && reg_wr_data == 16'h0000;
   endproperty
   a_defaults: assert property (p_defaults)
      else $error("defaults strobe without matching write");
   property p_pll_set;
      reg_wr_pulse && reg_wr_addr == 7'h40 && reg_wr_data == 16'h0001
         |=> pll_init_seen;
   endproperty
   a_pll_set: assert property (p_pll_set)
      else $error("init write not flagged");
   property p_pll_hold;
      pll_init_seen |=> pll_init_seen;
   endproperty
   a_pll_hold: assert property (p_pll_hold)
      else $error("init flag dropped");
   property p_awake_hold;
      iface_awake |=> iface_awake;
   endproperty
   a_awake_hold: assert property (p_awake_hold)
      else $error("awake flag dropped");
endmodule

bind tws_slave tws_slave_assertions tws_slave_assertions_inst (
   .clk, .rst, .ctl_serial_clock_line, .ctl_phase_select_line,
   .ctl_serial_data_line_o, .ctl_serial_data_line_oe, .bus_type_select_pin,
   .reg_wr_pulse, .reg_wr_addr, .reg_wr_data, .set_defaults_pulse,
   .pll_init_seen, .iface_awake);
